// >>> src/phy_link_dev.sv
// Physical-layer end: interface reset, disable, clock restart and start-up sequence
`timescale 1ns/100ps

module phy_link_dev #(
    parameter int WAKE_LP_CYC = phy_link_pkg::CLK_LP_MIN_CYC,
    parameter int DISABLE_CYC = phy_link_pkg::DISABLE_CYC
)
(
    phy_link_if.dev link,
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic nondiff_mode,
    input wire logic ports_active,
    output logic init_done,
    output logic link_disabled,
    output logic link_request
);

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    logic pwr_s1_q;
    logic pwr_s2_q;
    logic req_s1_q;
    logic req_s2_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pwr_s1_q <= 1'b0;
            pwr_s2_q <= 1'b0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end
        else
        begin
            pwr_s1_q <= link.link_power_status;
            pwr_s2_q <= pwr_s1_q;
            req_s1_q <= link.link_request_line;
            req_s2_q <= req_s1_q;
        end
    end

    // ========================================================================
    // Deassertion timer
    // ========================================================================
    logic [21:0] low_cnt_q;
    logic reset_hit;
    logic disable_hit;

    assign reset_hit = !pwr_s2_q && (low_cnt_q >= 22'(phy_link_pkg::RESET_CYC));
    assign disable_hit = !pwr_s2_q && (low_cnt_q >= 22'(DISABLE_CYC));

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || pwr_s2_q)
        begin
            low_cnt_q <= '0;
        end
        else if (!disable_hit)
        begin
            low_cnt_q <= low_cnt_q + 22'h000001;
        end
    end

    // ========================================================================
    // Interface clock synthesis
    // ========================================================================
    // Phase accumulator keeps the long-term rate exact; edges carry 4 ns jitter
    logic clk_run_q;
    logic [31:0] nco_q;
    logic ifc_q;
    logic [32:0] nco_sum;
    logic rise;

    assign nco_sum = {1'b0, nco_q} + {1'b0, phy_link_pkg::NCO_INC};
    assign rise = clk_run_q && nco_sum[32] && !ifc_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !clk_run_q)
        begin
            nco_q <= '0;
            ifc_q <= 1'b0;
        end
        else
        begin
            nco_q <= nco_sum[31:0];
            if (nco_sum[32])
            begin
                ifc_q <= ~ifc_q;
            end
        end
    end

    // ========================================================================
    // Sequence state
    // ========================================================================
    phy_link_pkg::dev_state_t state_q;
    logic [20:0] wake_cnt_q;
    logic [3:0] cyc_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q <= phy_link_pkg::ST_DISABLED;
            clk_run_q <= 1'b0;
            wake_cnt_q <= '0;
        end
        else if (disable_hit)
        begin
            state_q <= phy_link_pkg::ST_DISABLED;
            clk_run_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                phy_link_pkg::ST_DISABLED:
                begin
                    if (pwr_s2_q)
                    begin
                        state_q <= phy_link_pkg::ST_WAKE;
                        if (ports_active)
                        begin
                            // Entry, run flag and output enable flops eat three cycles
                            wake_cnt_q <= phy_link_pkg::CLK_FAST_CYC - 21'h000003;
                        end
                        else
                        begin
                            wake_cnt_q <= 21'(WAKE_LP_CYC - 1);
                        end
                    end
                end
                phy_link_pkg::ST_WAKE:
                begin
                    if (!pwr_s2_q)
                    begin
                        state_q <= phy_link_pkg::ST_DISABLED;
                    end
                    else if (wake_cnt_q == 21'h000000)
                    begin
                        state_q <= phy_link_pkg::ST_INIT;
                        clk_run_q <= 1'b1;
                    end
                    else
                    begin
                        wake_cnt_q <= wake_cnt_q - 21'h000001;
                    end
                end
                phy_link_pkg::ST_RESET:
                begin
                    if (pwr_s2_q)
                    begin
                        state_q <= phy_link_pkg::ST_INIT;
                    end
                end
                phy_link_pkg::ST_INIT:
                begin
                    if (reset_hit)
                    begin
                        state_q <= phy_link_pkg::ST_RESET;
                    end
                    else if (rise && cyc_q == phy_link_pkg::CYC_LAST_LOW)
                    begin
                        state_q <= phy_link_pkg::ST_RX;
                    end
                end
                phy_link_pkg::ST_RX:
                begin
                    if (reset_hit)
                    begin
                        state_q <= phy_link_pkg::ST_RESET;
                    end
                    else if (rise && cyc_q == phy_link_pkg::CYC_RX_LAST)
                    begin
                        state_q <= phy_link_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    if (reset_hit)
                    begin
                        state_q <= phy_link_pkg::ST_RESET;
                    end
                end
            endcase
        end
    end

    // ========================================================================
    // Interface clock cycle counter
    // ========================================================================
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !pwr_s2_q)
        begin
            cyc_q <= '0;
        end
        else if (state_q != phy_link_pkg::ST_INIT && state_q != phy_link_pkg::ST_RX)
        begin
            cyc_q <= '0;
        end
        else if (rise && cyc_q != phy_link_pkg::CYC_MAX)
        begin
            cyc_q <= cyc_q + 4'h1;
        end
    end

    // ========================================================================
    // Line drivers
    // ========================================================================
    // Registered, so lines follow the clock edge by one system cycle
    logic [1:0] ctl_d;
    logic [7:0] dat_d;
    logic oe_d;
    logic [1:0] ctl_q;
    logic [7:0] dat_q;
    logic oe_q;
    logic clk_oe_q;

    always_comb
    begin
        ctl_d = phy_link_pkg::CTL_IDLE;
        dat_d = phy_link_pkg::D_ZERO;
        oe_d = nondiff_mode;
        case (state_q)
            phy_link_pkg::ST_INIT:
            begin
                oe_d = nondiff_mode || (cyc_q == phy_link_pkg::CYC_LOW);
            end
            phy_link_pkg::ST_RX:
            begin
                ctl_d = phy_link_pkg::CTL_RX;
                dat_d = phy_link_pkg::D_ONES;
                oe_d = nondiff_mode || (cyc_q == phy_link_pkg::CYC_RX);
            end
            phy_link_pkg::ST_IDLE:
            begin
                oe_d = 1'b1;
            end
            default:
            begin
                oe_d = nondiff_mode;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctl_q <= phy_link_pkg::CTL_IDLE;
            dat_q <= phy_link_pkg::D_ZERO;
            oe_q <= 1'b0;
            clk_oe_q <= 1'b0;
        end
        else
        begin
            ctl_q <= ctl_d;
            dat_q <= dat_d;
            oe_q <= oe_d;
            // Differentiated mode floats a stopped clock, the other holds it low
            clk_oe_q <= clk_run_q || nondiff_mode;
        end
    end

    assign link.ifc_clk_o = ifc_q;
    assign link.ifc_clk_oe = clk_oe_q;
    assign link.dev_ctl_o = ctl_q;
    assign link.dev_ctl_oe = oe_q;
    assign link.dev_d_o = dat_q;
    assign link.dev_d_oe = oe_q;

    // ========================================================================
    // User-side status
    // ========================================================================
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            init_done <= 1'b0;
            link_disabled <= 1'b1;
            link_request <= 1'b0;
        end
        else
        begin
            init_done <= state_q == phy_link_pkg::ST_IDLE;
            link_disabled <= state_q == phy_link_pkg::ST_DISABLED;
            // Requests count only once start-up is complete
            link_request <= (state_q == phy_link_pkg::ST_IDLE) && req_s2_q;
        end
    end

endmodule : phy_link_dev

// >>> src/phy_link_pkg.sv
// Shared constants and types for the physical-layer to link-controller interface start-up
package phy_link_pkg;

    // ========================================================================
    // Line widths and encodings
    // ========================================================================
    localparam int CTL_W = 2;
    localparam int D_W = 8;
    localparam logic [1:0] CTL_IDLE = 2'h0;
    localparam logic [1:0] CTL_RX = 2'h2;
    localparam logic [7:0] D_ZERO = 8'h00;
    localparam logic [7:0] D_ONES = 8'hFF;

    // ========================================================================
    // Clock rates and interface clock synthesis
    // ========================================================================
    localparam longint SYS_FREQ_KHZ = 250000;
    localparam longint IFC_FREQ_KHZ = 49152;
    localparam int IFC_TOL_PPM = 100;
    // Phase step per system cycle; one carry per half period of the interface clock
    localparam logic [31:0] NCO_INC =
        32'((64'h0000_0001_0000_0000 * (2 * IFC_FREQ_KHZ)) / SYS_FREQ_KHZ);

    // ========================================================================
    // Timing
    // ========================================================================
    localparam longint CLK_FAST_NS = 60;
    localparam logic [20:0] CLK_FAST_CYC = 21'((CLK_FAST_NS * SYS_FREQ_KHZ) / 1000000);
    localparam longint CLK_LP_MIN_US = 5300;
    localparam longint CLK_LP_MAX_US = 7300;
    localparam int CLK_LP_MIN_CYC = int'((CLK_LP_MIN_US * SYS_FREQ_KHZ + 999) / 1000);
    localparam int CLK_LP_MAX_CYC = int'((CLK_LP_MAX_US * SYS_FREQ_KHZ) / 1000);
    localparam longint RESET_TIME_US = 3;
    localparam logic [20:0] RESET_CYC = 21'((RESET_TIME_US * SYS_FREQ_KHZ + 999) / 1000);
    localparam longint DISABLE_TIME_US = 25;
    localparam int DISABLE_CYC = int'((DISABLE_TIME_US * SYS_FREQ_KHZ + 999) / 1000);
    localparam longint RESTORE_TIME_US = 15;
    localparam logic [11:0] RESTORE_CYC =
        12'((RESTORE_TIME_US * SYS_FREQ_KHZ + 999) / 1000);

    // ========================================================================
    // Interface clock cycle numbers of the start-up sequence
    // ========================================================================
    localparam logic [3:0] CYC_LOW = 4'h1;
    localparam logic [3:0] CYC_LAST_LOW = 4'h7;
    localparam logic [3:0] CYC_RX = 4'h8;
    localparam logic [3:0] CYC_RX_LAST = 4'h9;
    localparam logic [3:0] CYC_MAX = 4'hF;

    typedef enum logic [2:0]
    {
        ST_DISABLED,
        ST_RESET,
        ST_WAKE,
        ST_INIT,
        ST_RX,
        ST_IDLE
    } dev_state_t;

endpackage : phy_link_pkg

// >>> src/phy_link_if.sv
// Pins between the physical-layer end and the link-controller end, with wire resolution
`timescale 1ns/100ps

interface phy_link_if;

    logic link_power_status;
    logic ifc_clk_o;
    logic ifc_clk_oe;
    logic [1:0] dev_ctl_o;
    logic dev_ctl_oe;
    logic [7:0] dev_d_o;
    logic dev_d_oe;
    logic [1:0] lnk_ctl_o;
    logic lnk_ctl_oe;
    logic [7:0] lnk_d_o;
    logic lnk_d_oe;
    logic lnk_req_o;
    logic lnk_req_oe;

    // Undriven lines settle at zero; no bus holder keeps the last driven value
    logic interface_clock_out;
    logic [1:0] control_lines;
    logic [7:0] transfer_lines;
    logic link_request_line;

    assign interface_clock_out = ifc_clk_o & ifc_clk_oe;
    assign control_lines = (dev_ctl_o & {2{dev_ctl_oe}}) | (lnk_ctl_o & {2{lnk_ctl_oe}});
    assign transfer_lines = (dev_d_o & {8{dev_d_oe}}) | (lnk_d_o & {8{lnk_d_oe}});
    assign link_request_line = lnk_req_o & lnk_req_oe;

    modport dev
    (
        input link_power_status,
        output ifc_clk_o,
        output ifc_clk_oe,
        output dev_ctl_o,
        output dev_ctl_oe,
        output dev_d_o,
        output dev_d_oe,
        input link_request_line
    );

    modport lnk
    (
        output link_power_status,
        input interface_clock_out,
        input control_lines,
        input transfer_lines,
        output lnk_ctl_o,
        output lnk_ctl_oe,
        output lnk_d_o,
        output lnk_d_oe,
        output lnk_req_o,
        output lnk_req_oe
    );

endinterface : phy_link_if

// >>> src/phy_link_ctl.sv
// Link-controller end: power status control and its part of the start-up sequence
`timescale 1ns/100ps

module phy_link_ctl
(
    phy_link_if.lnk link,
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic power_up,
    input wire logic nondiff_mode,
    input wire logic request,
    output logic init_done,
    output logic power_status
);

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    logic clk_s1_q;
    logic clk_s2_q;
    logic clk_prev_q;
    logic [1:0] ctl_s1_q;
    logic [1:0] ctl_s2_q;
    logic [7:0] d_s1_q;
    logic [7:0] d_s2_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_prev_q <= 1'b0;
            ctl_s1_q <= '0;
            ctl_s2_q <= '0;
            d_s1_q <= '0;
            d_s2_q <= '0;
        end
        else
        begin
            clk_s1_q <= link.interface_clock_out;
            clk_s2_q <= clk_s1_q;
            clk_prev_q <= clk_s2_q;
            ctl_s1_q <= link.control_lines;
            ctl_s2_q <= ctl_s1_q;
            d_s1_q <= link.transfer_lines;
            d_s2_q <= d_s1_q;
        end
    end

    // ========================================================================
    // Power status with restore interval
    // ========================================================================
    logic pwr_q;
    logic [11:0] low_cnt_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pwr_q <= 1'b0;
            low_cnt_q <= '0;
        end
        else
        begin
            pwr_q <= power_up && (pwr_q || low_cnt_q == phy_link_pkg::RESTORE_CYC);
            if (pwr_q)
            begin
                low_cnt_q <= '0;
            end
            else if (low_cnt_q != phy_link_pkg::RESTORE_CYC)
            begin
                low_cnt_q <= low_cnt_q + 12'h001;
            end
        end
    end

    // ========================================================================
    // Start-up tracking
    // ========================================================================
    logic [3:0] cyc_q;
    logic seen_rx_q;
    logic done_q;
    logic drv_low;

    assign drv_low = pwr_q && !done_q && (cyc_q == phy_link_pkg::CYC_LOW);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !pwr_q)
        begin
            cyc_q <= '0;
            seen_rx_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            if (clk_s2_q && !clk_prev_q && cyc_q != phy_link_pkg::CYC_MAX)
            begin
                cyc_q <= cyc_q + 4'h1;
            end
            if (ctl_s2_q == phy_link_pkg::CTL_RX && d_s2_q == phy_link_pkg::D_ONES)
            begin
                seen_rx_q <= 1'b1;
            end
            if (seen_rx_q && ctl_s2_q == phy_link_pkg::CTL_IDLE &&
                d_s2_q == phy_link_pkg::D_ZERO)
            begin
                done_q <= 1'b1;
            end
        end
    end

    // ========================================================================
    // Line drivers
    // ========================================================================
    logic lines_oe_q;
    logic req_o_q;
    logic req_oe_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            lines_oe_q <= 1'b0;
            req_o_q <= 1'b0;
            req_oe_q <= 1'b0;
            init_done <= 1'b0;
            power_status <= 1'b0;
        end
        else
        begin
            lines_oe_q <= drv_low;
            req_oe_q <= drv_low || done_q || nondiff_mode;
            req_o_q <= done_q && request;
            init_done <= done_q;
            power_status <= pwr_q;
        end
    end

    assign link.link_power_status = pwr_q;
    assign link.lnk_ctl_o = phy_link_pkg::CTL_IDLE;
    assign link.lnk_ctl_oe = lines_oe_q;
    assign link.lnk_d_o = phy_link_pkg::D_ZERO;
    assign link.lnk_d_oe = lines_oe_q;
    assign link.lnk_req_o = req_o_q;
    assign link.lnk_req_oe = req_oe_q;

endmodule : phy_link_ctl

// >>> dv/phy_link_properties.sv
// Concurrent checks on the pins between the two link ends
`timescale 1ns/100ps

module phy_link_properties #(
    parameter int DIS_CYC = 5000
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic link_power_status,
    input wire logic ifc_clk_oe,
    input wire logic interface_clock_out,
    input wire logic [1:0] dev_ctl_o,
    input wire logic dev_ctl_oe,
    input wire logic [7:0] dev_d_o,
    input wire logic dev_d_oe,
    input wire logic [1:0] lnk_ctl_o,
    input wire logic lnk_ctl_oe,
    input wire logic [7:0] lnk_d_o,
    input wire logic lnk_d_oe,
    input wire logic lnk_req_o,
    input wire logic lnk_req_oe
);
    // ====================
    // Helper counters
    // ====================
    logic [15:0] low_q;
    logic [3:0] stop_q;

    // Saturating, so a long disable never wraps into a false restart
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || link_power_status)
            low_q <= 16'h0000;
        else if (low_q != 16'hFFFF)
            low_q <= low_q + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || interface_clock_out)
            stop_q <= 4'h0;
        else if (stop_q != 4'hF)
            stop_q <= stop_q + 4'h1;
    end

    // ====================
    // Properties
    // ====================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_rx_hold;
        (dev_ctl_o == phy_link_pkg::CTL_RX)[*8];
    endsequence

    sequence s_idle_drive;
        ##[1:16] (dev_ctl_oe && dev_d_oe && dev_ctl_o == 2'h0 && dev_d_o == 8'h00);
    endsequence

    a_restore_wait: assert property ($rose(link_power_status) |->
        low_q + 16'h0001 >= 16'(phy_link_pkg::RESTORE_CYC))
        else $error("power status raised too early");
    a_reset_lines_zero: assert property (
        low_q > 16'(phy_link_pkg::RESET_CYC + 21'h8) |-> dev_ctl_o == 2'h0 && dev_d_o == 8'h00)
        else $error("lines not zero in reset state");
    a_disable_clk_stop: assert property (low_q > 16'(DIS_CYC + 8) |-> !interface_clock_out)
        else $error("clock runs while disabled");
    a_clk_half_period: assert property (@(posedge clk_sys)
        disable iff (!rst_n || !link_power_status) $rose(interface_clock_out) |->
        (interface_clock_out[*2] ##1 !interface_clock_out) or
        (interface_clock_out[*3] ##1 !interface_clock_out))
        else $error("clock high half out of range");
    a_clk_low_start: assert property ($rose(ifc_clk_oe) |-> !interface_clock_out[*2])
        else $error("clock did not start low");
    a_first_cycle_low: assert property (
        $rose(interface_clock_out) && stop_q >= 4'h8 |=>
        (dev_ctl_oe && dev_d_oe && dev_ctl_o == 2'h0 && dev_d_o == 8'h00)[*4])
        else $error("first clock cycle lines not driven low");
    a_rx_data_ones: assert property (dev_ctl_o == phy_link_pkg::CTL_RX |->
        dev_d_o == phy_link_pkg::D_ONES && dev_ctl_oe == dev_d_oe)
        else $error("receive state without all-ones data");
    a_rx_then_idle: assert property (@(posedge clk_sys)
        disable iff (!rst_n || !link_power_status)
        $rose(dev_ctl_o == phy_link_pkg::CTL_RX) |-> s_rx_hold ##0 s_idle_drive)
        else $error("receive indication not followed by idle");
    a_lnk_low_once: assert property ($rose(lnk_ctl_oe) |->
        (lnk_d_oe && lnk_req_oe && !lnk_req_o && lnk_ctl_o == 2'h0 && lnk_d_o == 8'h00)
        ##[2:10] !lnk_ctl_oe)
        else $error("controller low drive wrong");

endmodule : phy_link_properties

// >>> dv/testbench.sv
// Start-up bench with both link ends joined
`timescale 1ns/100ps

module testbench;
    typedef struct {logic nd; logic pa; int lo; int hi;} row_t;
    localparam int LP = 200;
    localparam int DIS = 5000;
    logic clk_sys, rst_n, nondiff_mode, ports_active, power_up, request;
    logic dev_done, dev_dis, dev_req, lnk_done, lnk_ps;
    int err_total, checks_done, n;
    row_t rows [4];

    phy_link_if bus();
    wire ico = bus.interface_clock_out;
    wire pwr = bus.link_power_status;

    phy_link_dev #(.WAKE_LP_CYC(LP), .DISABLE_CYC(DIS)) u_phy_link_dev (.link(bus),
        .clk_sys(clk_sys), .rst_n(rst_n), .nondiff_mode(nondiff_mode),
        .ports_active(ports_active), .init_done(dev_done), .link_disabled(dev_dis),
        .link_request(dev_req));
    phy_link_ctl u_phy_link_ctl (.link(bus), .clk_sys(clk_sys), .rst_n(rst_n),
        .power_up(power_up), .nondiff_mode(nondiff_mode), .request(request),
        .init_done(lnk_done), .power_status(lnk_ps));
    phy_link_properties #(.DIS_CYC(DIS)) u_phy_link_properties (.clk_sys(clk_sys),
        .rst_n(rst_n), .link_power_status(bus.link_power_status),
        .ifc_clk_oe(bus.ifc_clk_oe), .interface_clock_out(bus.interface_clock_out),
        .dev_ctl_o(bus.dev_ctl_o), .dev_ctl_oe(bus.dev_ctl_oe), .dev_d_o(bus.dev_d_o),
        .dev_d_oe(bus.dev_d_oe), .lnk_ctl_o(bus.lnk_ctl_o), .lnk_ctl_oe(bus.lnk_ctl_oe),
        .lnk_d_o(bus.lnk_d_o), .lnk_d_oe(bus.lnk_d_oe), .lnk_req_o(bus.lnk_req_o),
        .lnk_req_oe(bus.lnk_req_oe));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ====================
    // Tasks
    // ====================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int c);
        repeat (c) @(negedge clk_sys);
    endtask : cyc

    task automatic rises(input int c, output int r);
        logic pv;
        r = 0;
        pv = ico;
        repeat (c)
        begin
            cyc(1);
            r += int'(ico && !pv);
            pv = ico;
        end
    endtask : rises

    // Samples two cycles after each rise: lines settle one cycle after the edge
    task automatic walk(input logic nd);
        int k;
        logic pv;
        logic ex;
        k = 0;
        pv = 1'b0;
        for (int i = 0; i < 600 && k < 10; i++)
        begin
            if (ico && !pv)
            begin
                k++;
                cyc(2);
                ex = (k == 8 || k == 9);
                chk(bus.dev_ctl_oe, (k == 1 || k == 8 || k == 10) ? 1'b1 : nd);
                chk(bus.dev_ctl_o, ex ? phy_link_pkg::CTL_RX : phy_link_pkg::CTL_IDLE);
                chk(bus.dev_d_o, ex ? phy_link_pkg::D_ONES : phy_link_pkg::D_ZERO);
                if (k < 10)
                    chk({bus.lnk_req_oe | ~nd, bus.link_request_line, dev_req}, 3'h4);
            end
            pv = ico;
            cyc(1);
        end
        chk(k, 10);
    endtask : walk

    task automatic close_out;
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // ====================
    // Sequence
    // ====================
    initial
    begin
        err_total = 0;
        checks_done = 0;
        rst_n = 1'b0;
        nondiff_mode = 1'b0;
        ports_active = 1'b1;
        power_up = 1'b0;
        request = 1'b1;
        // Last row differentiated, so the long drop below sees a floated clock
        rows = '{'{1'b0, 1'b1, 3, 20}, '{1'b1, 1'b1, 3, 20},
            '{1'b1, 1'b0, LP, LP + 24}, '{1'b0, 1'b0, LP, LP + 24}};
        foreach (rows[i])
        begin
            nondiff_mode = rows[i].nd;
            ports_active = rows[i].pa;
            power_up = 1'b0;
            rst_n = 1'b0;
            cyc(16);
            rst_n = 1'b1;
            cyc(1);
            chk({dev_dis, dev_done, lnk_ps}, 3'h4);
            power_up = 1'b1;
            for (n = 0; !pwr && n < 5000; n++)
                cyc(1);
            for (n = 0; !ico && n < 400; n++)
                cyc(1);
            chk(n >= rows[i].lo && n <= rows[i].hi, 1'b1);
            walk(rows[i].nd);
            cyc(8);
            chk({dev_done, lnk_done, dev_req, lnk_ps}, 4'hF);
        end
        // Short drop: reset state only, clock must keep running
        power_up = 1'b0;
        cyc(900);
        chk({bus.dev_ctl_oe, bus.dev_ctl_o, bus.dev_d_o, dev_req, dev_dis, dev_done}, 14'h0000);
        rises(40, n);
        chk(n > 0, 1'b1);
        power_up = 1'b1;
        for (n = 0; !dev_done && n < 6000; n++)
            cyc(1);
        chk({dev_done, dev_dis}, 2'h2);
        power_up = 1'b0;
        cyc(DIS + 100);
        rises(40, n);
        chk({dev_dis, ico, bus.ifc_clk_oe, lnk_ps, n[7:0]}, 12'h800);
        close_out();
    end

    initial
    begin
        #400000;
        err_total++;
        close_out();
    end

endmodule : testbench
